// ### ecrb_pkg.sv
package ecrb_pkg;
   // =====================================================
   // Page numbers and shadow offsets
   localparam logic [3:0] PAGE_CUST     = 4'h0;
   localparam logic [3:0] PAGE_FRONT    = 4'h2;
   localparam logic [3:0] PAGE_DYN      = 4'h3;
   localparam int         NUM_REGS      = 15;
   localparam logic [3:0] OFS_CALIB_AXIS   = 4'h6;
   localparam logic [3:0] OFS_SER_POLE     = 4'h7;
   localparam logic [3:0] OFS_PWM_INDEX    = 4'h8;
   localparam logic [3:0] OFS_PSEL_INC_HI  = 4'h9;
   localparam logic [3:0] OFS_INC_LO       = 4'ha;
   localparam logic [3:0] OFS_HYST_DIR_ABS = 4'hb;
   localparam logic [3:0] OFS_ZERO_HI      = 4'hc;
   localparam logic [3:0] OFS_ZERO_MID     = 4'hd;
   localparam logic [3:0] OFS_ZERO_LO      = 4'he;
   localparam logic [3:0] OFS_DYN_OFFSET   = 4'h1;
   localparam logic [3:0] OFS_DYN_GAIN     = 4'h2;
   localparam logic [3:0] OFS_DYN_PHASE    = 4'h3;
   localparam logic [3:0] OFS_STAB_OFFSET  = 4'h5;
   localparam logic [3:0] OFS_FILTER_SEL   = 4'h8;
   localparam logic [3:0] OFS_MOTION       = 4'hc;
   localparam logic [3:0] OFS_COMP_MID     = 4'hd;
   localparam logic [3:0] OFS_COMP_LO      = 4'he;
   // =====================================================
   // Field positions
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_DIR      = 4;
   // =====================================================
   // Decode limits
   localparam logic [5:0] POLE_MAX     = 6'h20;
   localparam logic [2:0] PWM_MAX_CODE = 3'h4;
   localparam logic [4:0] PWM_MIN_BITS = 5'h0a;
   localparam logic [4:0] PWM_MAX_BITS = 5'h0e;
   localparam logic [4:0] ABS_MAX_BITS = 5'h12;
   localparam logic [3:0] ABS_MAX_CODE = 4'h8;
   localparam logic [4:0] ABS_MIN_BITS = 5'h08;
   localparam logic [14:0] INC_LIMIT   = 15'h4e20;
   localparam logic [15:0] GAIN_UNITY  = 16'h4000;
   localparam logic [2:0]  AXIS_ON     = 3'h0;
   localparam logic [2:0]  AXIS_RADIAL = 3'h5;
   localparam logic [2:0]  AXIS_AXIAL  = 3'h6;
   localparam logic [2:0]  AXIS_SIDE   = 3'h7;
   // =====================================================
   // Power-up defaults, one byte per offset
   localparam logic [7:0] CUST_RST [NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03,
      8'h00, 8'h04, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] FRONT_RST [NUM_REGS] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h0e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] DYN_RST [NUM_REGS] = '{
      8'h08, 8'h80, 8'h80, 8'h00, 8'h55, 8'h1f, 8'h1f, 8'h1f,
      8'h0b, 8'h53, 8'h16, 8'h03, 8'h5f, 8'h8c, 8'h5c};
   // =====================================================
   typedef enum logic [3:0] {
      ECRB_AXIS_ON = 4'b0001, ECRB_AXIS_RADIAL = 4'b0010,
      ECRB_AXIS_AXIAL = 4'b0100, ECRB_AXIS_SIDE = 4'b1000
   } ecrb_axis_e;
   typedef struct packed {
      logic        ext_cal_enable;
      logic [3:0]  axis_onehot;
      logic [3:0]  hall_select;
      logic        hall_valid;
      logic [1:0]  four_wire_frame_format;
      logic        commutation_outputs_on;
      logic [5:0]  pole_pairs;
      logic        pwm_fixed_clock;
      logic [4:0]  pwm_bits;
      logic [1:0]  index_width;
      logic [1:0]  index_state_ab;
      logic        protocol_second;
      logic [14:0] inc_resolution;
      logic        inc_enable;
      logic        inc_over_limit;
      logic [2:0]  inc_hyst_code;
      logic        count_ccw;
      logic [4:0]  abs_bits;
      logic [17:0] zero_offset;
   } ecrb_cust_s;
   typedef struct packed {
      logic [15:0] sine_gain;
      logic [15:0] cosine_gain;
      logic [15:0] sine_offset;
      logic [15:0] cosine_offset;
      logic [15:0] cosine_phase;
      logic        dyn_offset_en;
      logic        dyn_gain_en;
      logic        dyn_phase_en;
      logic [1:0]  phase_measure;
      logic [1:0]  phase_hyst;
      logic [5:0]  stab_start_state;
      logic [2:0]  stab_frozen;
      logic        dynamic_filter;
      logic [3:0]  filter_tc_code;
      logic [18:0] filter_comp;
   } ecrb_anlg_s;
endpackage

// ### ecrb_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module ecrb_register_bank
   import ecrb_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [3:0]        page_sel,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        wr_data,
   input  wire logic              calibration_trigger_pin,
   output logic      [7:0]        rd_data,
   output logic                   rd_valid,
   output logic                   calibration_start,
   output ecrb_pkg::ecrb_cust_s   cust_cfg,
   output ecrb_pkg::ecrb_anlg_s   anlg_cfg
);
   import ecrb_pkg::*;

   // =====================================================
   // Shadow storage for the three decoded pages
   logic [7:0] cust_q  [NUM_REGS];
   logic [7:0] front_q [NUM_REGS];
   logic [7:0] dyn_q   [NUM_REGS];
   logic       pin_meta_q;
   logic       pin_sync_q;
   logic       pin_prev_q;

   // Page steers which bank a write lands
   wire        sel_cust  = (page_sel == PAGE_CUST);
   wire        sel_front = (page_sel == PAGE_FRONT);
   wire        sel_dyn   = (page_sel == PAGE_DYN);
   wire        addr_ok   = (reg_addr < 4'(NUM_REGS));

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         wire hit = wr_en && (reg_addr == 4'(gi));
         // Byte stored as written, even invalid codes
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               cust_q[gi]  <= CUST_RST[gi];
               front_q[gi] <= FRONT_RST[gi];
               dyn_q[gi]   <= DYN_RST[gi];
            end else begin
               if (hit && sel_cust)
                  cust_q[gi] <= wr_data;
               if (hit && sel_front)
                  front_q[gi] <= wr_data;
               if (hit && sel_dyn)
                  dyn_q[gi] <= wr_data;
            end
         end
      end
   endgenerate

   // =====================================================
   // Readback; other pages and 0x0f read as zero
   wire [7:0] rd_mux =
      !addr_ok  ? 8'h00 :
      sel_cust  ? cust_q[reg_addr] :
      sel_front ? front_q[reg_addr] :
      sel_dyn   ? dyn_q[reg_addr] : 8'h00;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en)
            rd_data <= rd_mux;
      end
   end

   // =====================================================
   // Calibration pin: synchronised, then edge gated by enable
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_q        <= 1'b0;
         pin_sync_q        <= 1'b0;
         pin_prev_q        <= 1'b0;
         calibration_start <= 1'b0;
      end else begin
         pin_meta_q        <= calibration_trigger_pin;
         pin_sync_q        <= pin_meta_q;
         pin_prev_q        <= pin_sync_q;
         calibration_start <= pin_sync_q && !pin_prev_q &&
                              cust_q[OFS_CALIB_AXIS][BIT_ENABLE];
      end
   end

   // =====================================================
   // Customer page decode
   wire [7:0]  r6 = cust_q[OFS_CALIB_AXIS];
   wire [7:0]  r7 = cust_q[OFS_SER_POLE];
   wire [7:0]  r8 = cust_q[OFS_PWM_INDEX];
   wire [7:0]  r9 = cust_q[OFS_PSEL_INC_HI];
   wire [7:0]  rb = cust_q[OFS_HYST_DIR_ABS];
   wire [2:0]  axis_code = r6[6:4];
   wire [3:0]  hall      = r6[3:0];
   wire [5:0]  poles     = r7[5:0];
   wire [14:0] inc_res   = {r9[6:0], cust_q[OFS_INC_LO]};
   wire [3:0]  abs_code  = rb[3:0];

   ecrb_axis_e axis_d;
   always_comb begin
      case (axis_code)
         AXIS_ON:     axis_d = ECRB_AXIS_ON;
         AXIS_RADIAL: axis_d = ECRB_AXIS_RADIAL;
         AXIS_AXIAL:  axis_d = ECRB_AXIS_AXIAL;
         AXIS_SIDE:   axis_d = ECRB_AXIS_SIDE;
         default:     axis_d = ECRB_AXIS_ON;
      endcase
   end

   wire        hall_ok = (hall == 4'h8) || (hall == 4'h4) ||
                         (hall == 4'h2) || (hall == 4'h1);
   wire [5:0]  pole_d  = (poles > POLE_MAX) ? POLE_MAX : poles;
   wire [4:0]  pwm_d   = (r8[6:4] > PWM_MAX_CODE) ? PWM_MAX_BITS :
                         PWM_MIN_BITS + {2'h0, r8[6:4]};
   // Code 1000 gives 10 bits; beyond that the floor is 8
   wire [4:0]  abs_d   = (abs_code > ABS_MAX_CODE) ? ABS_MIN_BITS :
                         ABS_MAX_BITS - {1'b0, abs_code};
   // Quadrature state for index: 00,01,11,10 in gray order
   wire [1:0]  idx_ab  = {r8[1], r8[1] ^ r8[0]};

   ecrb_cust_s cust_d;
   always_comb begin
      cust_d                        = '0;
      cust_d.ext_cal_enable         = r6[BIT_ENABLE];
      cust_d.axis_onehot            = axis_d;
      cust_d.hall_select            = hall;
      // Selector only means something off-axis
      cust_d.hall_valid             = hall_ok && (axis_d != ECRB_AXIS_ON);
      cust_d.four_wire_frame_format = r7[7:6];
      cust_d.commutation_outputs_on = (poles != 6'h00);
      cust_d.pole_pairs             = pole_d;
      cust_d.pwm_fixed_clock        = r8[7];
      cust_d.pwm_bits               = pwm_d;
      cust_d.index_width            = r8[3:2];
      cust_d.index_state_ab         = idx_ab;
      cust_d.protocol_second        = r9[BIT_ENABLE];
      cust_d.inc_resolution         = inc_res;
      cust_d.inc_enable             = (inc_res != 15'h0000);
      cust_d.inc_over_limit         = (inc_res > INC_LIMIT);
      cust_d.inc_hyst_code          = rb[7:5];
      cust_d.count_ccw              = rb[BIT_DIR];
      cust_d.abs_bits               = abs_d;
      cust_d.zero_offset            = {cust_q[OFS_ZERO_HI],
                                       cust_q[OFS_ZERO_MID],
                                       cust_q[OFS_ZERO_LO][7:6]};
   end

   // =====================================================
   // Front-end and dynamic page decode
   wire [15:0] sg_raw = {front_q[0], front_q[1]};
   wire [15:0] cg_raw = {front_q[2], front_q[3]};
   // Zero gain is an exception meaning unity, not mute
   wire [15:0] sg_d   = (sg_raw == 16'h0000) ? GAIN_UNITY : sg_raw;
   wire [15:0] cg_d   = (cg_raw == 16'h0000) ? GAIN_UNITY : cg_raw;
   wire [7:0]  d5     = dyn_q[OFS_STAB_OFFSET];
   wire [7:0]  d6     = dyn_q[OFS_STAB_OFFSET + 4'h1];
   wire [7:0]  d7     = dyn_q[OFS_STAB_OFFSET + 4'h2];
   wire [3:0]  flt    = dyn_q[OFS_FILTER_SEL][7:4];

   ecrb_anlg_s anlg_d;
   always_comb begin
      anlg_d                  = '0;
      anlg_d.sine_gain        = sg_d;
      anlg_d.cosine_gain      = cg_d;
      anlg_d.sine_offset      = {front_q[4], front_q[5]};
      anlg_d.cosine_offset    = {front_q[6], front_q[7]};
      anlg_d.cosine_phase     = {front_q[12], front_q[13]};
      anlg_d.dyn_offset_en    = dyn_q[OFS_DYN_OFFSET][BIT_ENABLE];
      anlg_d.dyn_gain_en      = dyn_q[OFS_DYN_GAIN][BIT_ENABLE];
      anlg_d.dyn_phase_en     = dyn_q[OFS_DYN_PHASE][BIT_ENABLE];
      anlg_d.phase_measure    = dyn_q[OFS_DYN_GAIN][1:0];
      anlg_d.phase_hyst       = dyn_q[OFS_DYN_PHASE][1:0];
      // Start states: offset, gain, phase from low to high
      anlg_d.stab_start_state = {d7[1:0], d6[1:0], d5[1:0]};
      anlg_d.stab_frozen      = {d7[3:2] == 2'h0, d6[3:2] == 2'h0,
                                 d5[3:2] == 2'h0};
      anlg_d.dynamic_filter   = (flt == 4'h0);
      anlg_d.filter_tc_code   = flt;
      anlg_d.filter_comp      = {dyn_q[OFS_MOTION][2:0],
                                 dyn_q[OFS_COMP_MID],
                                 dyn_q[OFS_COMP_LO]};
   end

   // =====================================================
   // Registered outputs; one cycle after a write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cust_cfg <= '0;
         anlg_cfg <= '0;
      end else begin
         cust_cfg <= cust_d;
         anlg_cfg <= anlg_d;
      end
   end
endmodule
`default_nettype wire

// ### ecrb_register_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ecrb_register_bank_assertions
   import ecrb_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 rst_b,
   input wire logic [3:0]           page_sel,
   input wire logic                 wr_en,
   input wire logic                 rd_en,
   input wire logic [3:0]           reg_addr,
   input wire logic [7:0]           wr_data,
   input wire logic                 calibration_trigger_pin,
   input wire logic [7:0]           rd_data,
   input wire logic                 rd_valid,
   input wire logic                 calibration_start,
   input wire ecrb_pkg::ecrb_cust_s cust_cfg,
   input wire ecrb_pkg::ecrb_anlg_s anlg_cfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ==========
   // Writes reach the decode two edges after they are taken
   sequence s_cal_wr;
      wr_en && page_sel == PAGE_CUST && reg_addr == OFS_CALIB_AXIS;
   endsequence
   sequence s_zero_wr;
      wr_en && page_sel == PAGE_CUST && reg_addr == OFS_ZERO_LO;
   endsequence
   chk_cal_write: assert property (s_cal_wr |-> ##2
      cust_cfg.ext_cal_enable == $past(wr_data[7], 2))
      else $error("calibration enable missed its write");
   chk_zero_write: assert property (s_zero_wr |-> ##2
      cust_cfg.zero_offset[1:0] == $past(wr_data[7:6], 2))
      else $error("zero offset low bits wrong");
   // Synchroniser plus edge register: start lands a few edges after the pin
   chk_cal_start: assert property ($rose(calibration_trigger_pin) &&
      cust_cfg.ext_cal_enable |-> ##[1:4] calibration_start)
      else $error("calibration start missing");
   chk_unmapped_read: assert property (rd_en && reg_addr == 4'hf
      |=> rd_valid && rd_data == 8'h00) else $error("unmapped read");
   chk_read_hold: assert property (!rd_en |=>
      !rd_valid && $stable(rd_data)) else $error("read data moved");
   chk_pole_clamp: assert property (cust_cfg.pole_pairs <= POLE_MAX &&
      cust_cfg.commutation_outputs_on == (cust_cfg.pole_pairs != 6'h00))
      else $error("pole pair decode wrong");
   // Skip the release edge: outputs there still show reset values
   chk_abs_range: assert property ($past(rst_b) |->
      cust_cfg.abs_bits inside {[5'h08:5'h12]}) else $error("abs bits");
   chk_inc_flags: assert property (
      cust_cfg.inc_over_limit == (cust_cfg.inc_resolution > INC_LIMIT) &&
      cust_cfg.inc_enable == (cust_cfg.inc_resolution != 15'h0000))
      else $error("incremental flags wrong");
   chk_axis_onehot: assert property ($past(rst_b) |->
      $onehot(cust_cfg.axis_onehot)) else $error("axis not one-hot");
endmodule
bind ecrb_register_bank ecrb_register_bank_assertions chk_i (
   .ref_clk(ref_clk), .rst_b(rst_b), .page_sel(page_sel), .wr_en(wr_en),
   .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data),
   .calibration_trigger_pin(calibration_trigger_pin), .rd_data(rd_data),
   .rd_valid(rd_valid), .calibration_start(calibration_start),
   .cust_cfg(cust_cfg), .anlg_cfg(anlg_cfg));
`default_nettype wire

// ### ecrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecrb_host_model
   import ecrb_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output logic      [3:0] page_sel,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [3:0] reg_addr,
   output logic      [7:0] wr_data
);
   initial {page_sel, wr_en, rd_en, reg_addr, wr_data} = '0;
   // ==========
   // Byte write, then two edges for storage and decode
   task automatic wr(input logic [3:0] pg, a, input logic [7:0] d);
      @(negedge ref_clk);
      {page_sel, reg_addr, wr_en} = {pg, a, 1'b1};
      wr_data = d;
      @(negedge ref_clk);
      wr_en = 1'b0;
      // Idle data is inverted so a stale byte never looks valid
      wr_data = ~d;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] pg, a, output logic [7:0] d,
                     output logic v);
      @(negedge ref_clk);
      {page_sel, reg_addr, rd_en} = {pg, a, 1'b1};
      @(negedge ref_clk);
      {rd_en, d, v} = {1'b0, rd_data, rd_valid};
   endtask
endmodule
`default_nettype wire

// ### ecrb_register_bank_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
module ecrb_register_bank_test;
   import ecrb_pkg::*;
   logic       ref_clk, rst_b, calibration_trigger_pin, wr_en, rd_en;
   logic       rd_valid, calibration_start, rv, seen;
   logic [3:0] page_sel, reg_addr, lc;
   logic [4:0] eb;
   logic [7:0] wr_data, rd_data, rb;
   ecrb_cust_s cust_cfg;
   ecrb_anlg_s anlg_cfg;
   int         n_mismatch, checked, cycles;
   ecrb_register_bank uut (.ref_clk(ref_clk), .rst_b(rst_b),
      .page_sel(page_sel), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
      .wr_data(wr_data), .calibration_trigger_pin(calibration_trigger_pin),
      .rd_data(rd_data), .rd_valid(rd_valid), .cust_cfg(cust_cfg),
      .calibration_start(calibration_start), .anlg_cfg(anlg_cfg));
   ecrb_host_model host (.ref_clk(ref_clk), .rd_data(rd_data),
      .rd_valid(rd_valid), .page_sel(page_sel), .wr_en(wr_en),
      .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data));
   // ==========
   // Clock and hang guard, ceiling well above the few hundred cycles used
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rdchk(input logic [3:0] pg, a, input logic [7:0] x);
      host.rd(pg, a, rb, rv);
      `CHK({rv, rb}, {1'b1, x})
   endtask
   // ==========
   // Scenarios
   task automatic t_axis();
      logic [2:0] ax [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
      for (int i = 0; i < 4; i++) begin
         host.wr(PAGE_CUST, OFS_CALIB_AXIS, {1'b0, ax[i], 4'h8});
         `CHK(cust_cfg.axis_onehot, 4'h1 << i)
         `CHK(cust_cfg.hall_valid, i != 0)
      end
      host.wr(PAGE_CUST, OFS_CALIB_AXIS, 8'h3f);
      host.wr(4'h1, OFS_CALIB_AXIS, 8'hff);
      rdchk(PAGE_CUST, OFS_CALIB_AXIS, 8'h3f);
      `CHK(cust_cfg.hall_valid, 1'b0)
      rdchk(PAGE_CUST, 4'hf, 8'h00);
   endtask
   task automatic t_codes();
      for (int c = 0; c < 16; c++) begin
         lc = 4'(c);
         host.wr(PAGE_CUST, OFS_SER_POLE, {lc[1:0], lc, lc[1:0]});
         host.wr(PAGE_CUST, OFS_PWM_INDEX, {lc, lc});
         host.wr(PAGE_CUST, OFS_HYST_DIR_ABS, {lc[2:0], lc[0], lc});
         `CHK(cust_cfg.four_wire_frame_format, lc[1:0])
         `CHK(cust_cfg.pole_pairs, (c > 8) ? 6'h20 : {lc, lc[1:0]})
         eb = (lc[2:0] > 3'h4) ? 5'h0e : 5'h0a + {2'h0, lc[2:0]};
         `CHK({cust_cfg.pwm_fixed_clock, cust_cfg.pwm_bits}, {lc[3], eb})
         `CHK({cust_cfg.index_width, cust_cfg.index_state_ab}, {lc[3:1], ^lc[1:0]})
         eb = (lc > 4'h8) ? 5'h08 : 5'h12 - {1'b0, lc};
         `CHK(cust_cfg.abs_bits, eb)
         `CHK({cust_cfg.inc_hyst_code, cust_cfg.count_ccw}, {lc[2:0], lc[0]})
      end
   endtask
   task automatic t_inc_zero();
      host.wr(PAGE_CUST, OFS_PSEL_INC_HI, 8'hce);
      host.wr(PAGE_CUST, OFS_INC_LO, 8'h21);
      `CHK(cust_cfg.protocol_second, 1'b1)
      `CHK(cust_cfg.inc_over_limit, 1'b1)
      host.wr(PAGE_CUST, OFS_INC_LO, 8'h20);
      `CHK(cust_cfg.inc_resolution, 15'h4e20)
      host.wr(PAGE_CUST, OFS_ZERO_HI, 8'ha5);
      host.wr(PAGE_CUST, OFS_ZERO_MID, 8'h3c);
      host.wr(PAGE_CUST, OFS_ZERO_LO, 8'hc0);
      `CHK(cust_cfg.zero_offset, {8'ha5, 8'h3c, 2'h3})
      rst_b = 1'b0;
      @(negedge ref_clk);
      rst_b = 1'b1;
      rdchk(PAGE_CUST, OFS_ZERO_HI, 8'h00);
   endtask
   task automatic t_anlg();
      `CHK(anlg_cfg.filter_comp, 19'h78c5c)
      `CHK({anlg_cfg.dyn_phase_en, anlg_cfg.phase_hyst}, 3'h0)
      host.wr(PAGE_DYN, OFS_DYN_GAIN, 8'h82);
      host.wr(PAGE_DYN, OFS_DYN_PHASE, 8'h83);
      `CHK({anlg_cfg.dyn_gain_en, anlg_cfg.phase_measure}, 3'h6)
      `CHK({anlg_cfg.dyn_phase_en, anlg_cfg.phase_hyst}, 3'h7)
      host.wr(PAGE_FRONT, 4'h2, 8'hff);
      host.wr(PAGE_FRONT, 4'h4, 8'h80);
      host.wr(PAGE_DYN, OFS_DYN_OFFSET, 8'h00);
      host.wr(PAGE_DYN, OFS_STAB_OFFSET, 8'h02);
      host.wr(PAGE_DYN, OFS_FILTER_SEL, 8'hfb);
      host.wr(PAGE_DYN, OFS_COMP_LO, 8'h50);
      host.wr(PAGE_DYN, OFS_MOTION, 8'h5d);
      `CHK(anlg_cfg.sine_gain, 16'h4000)
      `CHK(anlg_cfg.cosine_gain, 16'hff00)
      `CHK(anlg_cfg.sine_offset, 16'h8000)
      `CHK(anlg_cfg.dyn_offset_en, 1'b0)
      `CHK(anlg_cfg.stab_frozen[0], 1'b1)
      `CHK(anlg_cfg.stab_start_state[1:0], 2'h2)
      `CHK({anlg_cfg.dynamic_filter, anlg_cfg.filter_tc_code}, 5'h0f)
      `CHK(anlg_cfg.filter_comp, 19'h58c50)
   endtask
   task automatic t_cal();
      for (int e = 0; e < 2; e++) begin
         host.wr(PAGE_CUST, OFS_CALIB_AXIS, (e == 0) ? 8'h80 : 8'h00);
         seen = 1'b0;
         calibration_trigger_pin = 1'b1;
         repeat (6) @(negedge ref_clk) seen |= calibration_start;
         calibration_trigger_pin = 1'b0;
         `CHK(seen, e == 0)
      end
   endtask
   initial begin
      rst_b = 1'b0;
      calibration_trigger_pin = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      t_axis();
      t_codes();
      t_inc_zero();
      t_anlg();
      t_cal();
      complete_run();
   end
endmodule
`default_nettype wire
